/* design/ictrim_map.sv */
`timescale 1ns/1ns
module ictrim_map (
    input wire logic [15:0] i_ofs_word,
    input wire logic [15:0] i_fs_word,
    output logic signed [8:0] o_ofs_step,
    output logic [8:0] o_fs_code,
    output logic [1:0] o_fill_ok
);
    logic [7:0] mag;

    // Sign-magnitude to two's complement step count
    always_comb begin
        mag = i_ofs_word[ictrim_pkg::OFS_MAG_LSB +: ictrim_pkg::OFS_MAG_W];  // [R1]
        if (i_ofs_word[ictrim_pkg::OFS_SIGN_BIT]) begin
            o_ofs_step = -$signed({1'b0, mag});  // [R3]
        end else begin
            o_ofs_step = $signed({1'b0, mag});
        end
    end

    // Gain code passes straight through; linear in the analogue block
    assign o_fs_code = i_fs_word[ictrim_pkg::FS_LSB +: ictrim_pkg::FS_W];  // [R5]
    // Fill bits seen as written, for software diagnostics
    assign o_fill_ok = {i_fs_word[ictrim_pkg::FILL_W-1:0] == ictrim_pkg::FILL_ONES,
                        i_ofs_word[ictrim_pkg::FILL_W-1:0] == ictrim_pkg::FILL_ONES};
endmodule : ictrim_map

/* design/ictrim_regs.sv */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// Functional notes
// R1: Offset magnitude in bits 15:8, linear
// R2: Zero gives none, all ones 45 mV
// R3: Bit 7 chooses negative offset polarity
// R4: Reset clears offset magnitude and sign
// R5: Nine-bit gain code in bits 15:7
// R6: Gain code spans minus to plus 20 percent
// R7: Host keeps gain code within recommended bounds
// R8: Gain change applies without recalibration
// R9: Reset loads midscale gain code
// R10: Host writes ones into low seven bits
module ictrim_regs (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [ictrim_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ictrim_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic signed [8:0] o_ofs_step,
    output logic [8:0] o_fs_code,
    output logic o_fs_update
);
    // -------------------------------------------------------------------
    // Write channel capture
    // -------------------------------------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [ictrim_pkg::ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [15:0] ofs_r;
    logic [15:0] fs_r;
    logic [1:0] fill_ok_r;
    logic signed [8:0] ofs_step;
    logic [8:0] fs_code;
    logic [1:0] fill_ok;
    logic do_write;
    logic [3:0] widx;
    logic [3:0] ridx;
    logic [15:0] merged;

    assign o_awready = !aw_held_r && !o_bvalid;
    assign o_wready = !w_held_r && !o_bvalid;
    assign do_write = aw_held_r && w_held_r && !o_bvalid;
    assign widx = awaddr_r[5:2];
    assign ridx = i_araddr[5:2];

    // Address and data may arrive in either order
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= i_awaddr;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Byte-lane merge of the low halfword
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v);
        lane_merge = old_v;
        if (wstrb_r[0]) begin
            lane_merge[7:0] = wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
            lane_merge[15:8] = wdata_r[15:8];
        end
    endfunction : lane_merge

    always_comb begin
        merged = 16'h0000;
        if (widx == ictrim_pkg::OFFSET_IDX) begin
            merged = lane_merge(ofs_r);
        end else if (widx == ictrim_pkg::FULL_SCALE_IDX) begin
            merged = lane_merge(fs_r);
        end
    end

    // -------------------------------------------------------------------
    // Trim registers
    // -------------------------------------------------------------------
    // Offset word; reset leaves no offset applied
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ofs_r <= ictrim_pkg::OFFSET_RST;  // [R4]
        end else if (do_write && widx == ictrim_pkg::OFFSET_IDX) begin
            ofs_r <= merged;  // [R2]
        end
    end

    // Gain word; reset value is midscale, no adjustment
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fs_r <= ictrim_pkg::FULL_SCALE_RST;  // [R9]
        end else if (do_write && widx == ictrim_pkg::FULL_SCALE_IDX) begin
            fs_r <= merged;  // [R6]
        end
    end

    // Field decode shared with the analogue interface
    ictrim_map u_map (
        .i_ofs_word(ofs_r),
        .i_fs_word(fs_r),
        .o_ofs_step(ofs_step),
        .o_fs_code(fs_code),
        .o_fill_ok(fill_ok)
    );

    // Registered trims; gain takes effect directly, no calibration request
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ofs_step <= 9'sh000;
            o_fs_code <= ictrim_pkg::FULL_SCALE_RST[15:7];  // [R9]
            o_fs_update <= 1'b0;
            fill_ok_r <= 2'h3;
        end else begin
            o_ofs_step <= ofs_step;  // [R1]
            o_fs_code <= fs_code;  // [R8]
            o_fs_update <= (o_fs_code != fs_code);  // [R8]
            fill_ok_r <= fill_ok;  // [R10]
        end
    end

    // -------------------------------------------------------------------
    // Write response
    // -------------------------------------------------------------------
    // Trims are write-only; unmapped writes get SLVERR
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bvalid <= 1'b0;
            o_bresp <= ictrim_pkg::RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            if (widx == ictrim_pkg::OFFSET_IDX || widx == ictrim_pkg::FULL_SCALE_IDX) begin
                o_bresp <= ictrim_pkg::RESP_OKAY;
            end else begin
                o_bresp <= ictrim_pkg::RESP_SLVERR;
            end
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------------
    assign o_arready = !o_rvalid;

    // Trim words read as zero with SLVERR; only status is readable
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= ictrim_pkg::RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            if (ridx == ictrim_pkg::STATUS_IDX) begin
                o_rdata <= {30'h00000000, fill_ok_r};
                o_rresp <= ictrim_pkg::RESP_OKAY;
            end else begin
                o_rdata <= 32'h00000000;
                o_rresp <= ictrim_pkg::RESP_SLVERR;
            end
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end
endmodule : ictrim_regs

/* pkg/ictrim_pkg.sv */
package ictrim_pkg;
    // -------------------------------------------------------------------
    // Register map (printed offsets are not multiples of four: indices)
    // -------------------------------------------------------------------
    localparam logic [3:0] OFFSET_IDX = 4'h2;
    localparam logic [3:0] FULL_SCALE_IDX = 4'h3;
    localparam logic [3:0] STATUS_IDX = 4'h4;
    localparam int ADDR_W = 6;

    // -------------------------------------------------------------------
    // Field layout
    // -------------------------------------------------------------------
    localparam int OFS_MAG_LSB = 8;
    localparam int OFS_MAG_W = 8;
    localparam int OFS_SIGN_BIT = 7;
    localparam int FS_LSB = 7;
    localparam int FS_W = 9;
    localparam int FILL_W = 7;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [15:0] OFFSET_RST = 16'h007F;
    localparam logic [15:0] FULL_SCALE_RST = 16'h807F;
    localparam logic [6:0] FILL_ONES = 7'h7F;

    // -------------------------------------------------------------------
    // Analogue endpoints, in microvolts
    // -------------------------------------------------------------------
    localparam int OFS_FULL_UV = 45000;
    localparam int FS_NOM_UV = 700000;
    localparam int FS_MIN_UV = 560000;
    localparam int FS_MAX_UV = 840000;

    // -------------------------------------------------------------------
    // AXI4-Lite responses
    // -------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ictrim_pkg

/* sim/ictrim_host.sv */
`timescale 1ns/1ns
module ictrim_host (
    input wire logic i_clk,
    input wire logic i_awready,
    input wire logic i_wready,
    input wire logic i_bvalid,
    input wire logic i_arready,
    input wire logic i_rvalid,
    input wire logic [1:0] i_bresp,
    input wire logic [1:0] i_rresp,
    input wire logic [31:0] i_rdata,
    output logic o_awvalid,
    output logic o_wvalid,
    output logic o_bready,
    output logic o_arvalid,
    output logic o_rready,
    output logic [5:0] o_awaddr,
    output logic [5:0] o_araddr,
    output logic [31:0] o_wdata,
    output logic [3:0] o_wstrb
);
    initial {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_awaddr, o_araddr} = '0;
    initial {o_wdata, o_wstrb} = '0;
    // Write; released lines show inverted values so stale data never matches
    task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ao = 1'b1;
        logic wo = 1'b1;
        @(posedge i_clk);
        o_awaddr <= a;
        o_wdata <= {d[31:7], ictrim_pkg::FILL_ONES};
        o_wstrb <= 4'hF;
        {o_awvalid, o_wvalid, o_bready} <= 3'h7;
        while (ao || wo) begin
            @(posedge i_clk);
            // Each channel released only at the edge that took it
            if (ao && i_awready) begin
                ao = 1'b0;
                o_awvalid <= 1'b0;
                o_awaddr <= ~a;
            end
            if (wo && i_wready) begin
                wo = 1'b0;
                o_wvalid <= 1'b0;
                o_wdata <= ~d;
            end
        end
        do @(posedge i_clk); while (!i_bvalid);
        r = i_bresp;
        o_bready <= 1'b0;
    endtask : wr
    // Read; rready held until rvalid is seen
    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        o_araddr <= a;
        {o_arvalid, o_rready} <= 2'h3;
        do @(posedge i_clk); while (!i_arready);
        {o_arvalid, o_araddr} <= {1'b0, ~a};
        do @(posedge i_clk); while (!i_rvalid);
        {d, r} = {i_rdata, i_rresp};
        o_rready <= 1'b0;
    endtask : rd
endmodule : ictrim_host

/* sim/ictrim_props.sv */
`timescale 1ns/1ns
module ictrim_props (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic o_fs_update,
    input wire logic [ictrim_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic [ictrim_pkg::ADDR_W-1:0] i_araddr,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_bresp,
    input wire logic [1:0] o_rresp,
    input wire logic signed [8:0] o_ofs_step,
    input wire logic [8:0] o_fs_code
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Both write channels taken at one edge
    wire logic wr_go = i_awvalid && o_awready && i_wvalid && o_wready;
    wire logic wr_ofs = wr_go && i_awaddr[5:2] == ictrim_pkg::OFFSET_IDX;
    wire logic wr_fs = wr_go && i_awaddr[5:2] == ictrim_pkg::FULL_SCALE_IDX;
    // Expected step: magnitude from bits 15:8, bit 7 negates it
    wire logic signed [8:0] ofs_want = i_wdata[7] ? -$signed({1'b0, i_wdata[15:8]})
                                                  : $signed({1'b0, i_wdata[15:8]});
    ofs_reset_a: assert property ($rose(i_reset_n) |-> o_ofs_step == 9'h000)
        else $error("offset not clear after reset");
    fs_reset_a: assert property ($rose(i_reset_n) |-> o_fs_code == 9'h100)
        else $error("gain not midscale after reset");
    ofs_write_a: assert property (wr_ofs |-> ##3 o_ofs_step == $past(ofs_want, 3))
        else $error("offset step wrong after write");
    fs_write_a: assert property (wr_fs |-> ##3 o_fs_code == $past(i_wdata[15:7], 3))
        else $error("gain code wrong after write");
    // Update pulse stands in the same cycle as the new gain code
    fs_pulse_a: assert property (o_fs_code != $past(o_fs_code) |-> o_fs_update)
        else $error("gain change without update pulse");
    fs_quiet_a: assert property (o_fs_update |-> o_fs_code != $past(o_fs_code))
        else $error("update pulse without gain change");
    write_ok_a: assert property ((wr_ofs || wr_fs) |-> ##2 o_bvalid && o_bresp == 2'h0)
        else $error("trim write not answered okay");
    ofs_span_a: assert property (o_ofs_step != 9'h100)
        else $error("offset step beyond full magnitude");
    rd_wo_a: assert property (i_arvalid && o_arready && i_araddr[5:3] == 3'h1
        |=> o_rvalid && o_rresp == ictrim_pkg::RESP_SLVERR && o_rdata == 32'h0)
        else $error("trim register readable");
    cover property (wr_ofs);
    cover property (o_fs_update);
    cover property (o_rvalid && o_rresp == ictrim_pkg::RESP_SLVERR);
endmodule : ictrim_props
bind ictrim_regs ictrim_props chk (.*);

/* sim/test_i_channel_trim_registers.sv */
`timescale 1ns/1ns
module test_i_channel_trim_registers;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    wire logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready, o_fs_update;
    wire logic i_arvalid, o_arready, o_rvalid, i_rready;
    wire logic [5:0] i_awaddr, i_araddr;
    wire logic [31:0] i_wdata, o_rdata;
    wire logic [3:0] i_wstrb;
    wire logic [1:0] o_bresp, o_rresp;
    wire logic signed [8:0] o_ofs_step;
    wire logic [8:0] o_fs_code;
    int fail_count = 0, samples_checked = 0, cyc = 0, pulses = 0;
    logic [31:0] rdat;
    logic [1:0] resp;
    always #20 i_clk = ~i_clk;
    ictrim_regs dut (.*);
    ictrim_host host (.i_clk(i_clk), .i_awready(o_awready), .i_wready(o_wready),
        .i_bvalid(o_bvalid), .i_arready(o_arready), .i_rvalid(o_rvalid), .i_bresp(o_bresp),
        .i_rresp(o_rresp), .i_rdata(o_rdata), .o_awvalid(i_awvalid), .o_wvalid(i_wvalid),
        .o_bready(i_bready), .o_arvalid(i_arvalid), .o_rready(i_rready), .o_awaddr(i_awaddr),
        .o_araddr(i_araddr), .o_wdata(i_wdata), .o_wstrb(i_wstrb));
    // Pulse count and hang guard
    always @(posedge i_clk) begin
        cyc++;
        pulses += int'(o_fs_update);
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic complete_run();
        if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic t_reset();
        chk("ofs_rst", {23'h0, o_ofs_step}, 32'h0);
        chk("fs_rst", {23'h0, o_fs_code}, 32'h100);
    endtask : t_reset
    // Sign on zero magnitude, both extremes, smallest negative step
    task automatic t_offset();
        logic [15:0] w [5] = '{16'h00FF, 16'hFF7F, 16'hFFFF, 16'h01FF, 16'h807F};
        logic [8:0] e [5] = '{9'h000, 9'h0FF, 9'h101, 9'h1FF, 9'h080};
        foreach (w[k]) begin
            host.wr(6'h08, {16'h0, w[k]}, resp);
            repeat (3) @(posedge i_clk);
            chk("ofs", {21'h0, o_ofs_step, resp}, {21'h0, e[k], 2'h0});
        end
    endtask : t_offset
    // Range ends, advised bounds, back to midscale
    task automatic t_fs();
        logic [8:0] c [5] = '{9'h000, 9'h1FF, 9'h0C0, 9'h1C0, 9'h100};
        int p;
        foreach (c[k]) begin
            p = pulses;
            host.wr(6'h0C, {16'h0, c[k], 7'h7F}, resp);
            repeat (3) @(posedge i_clk);
            chk("fs", {23'h0, o_fs_code}, {23'h0, c[k]});
            chk("fs_pulse", 32'(pulses - p), 32'h1);
            chk("fs_resp", {30'h0, resp}, 32'h0);
        end
    endtask : t_fs
    // Unmapped write has no effect; trims cannot be read back
    task automatic t_bad();
        host.wr(6'h14, 32'hFFFF, resp);
        repeat (3) @(posedge i_clk);
        chk("unmapped", {21'h0, o_fs_code, resp}, {21'h0, 9'h100, 2'h2});
        host.rd(6'h08, rdat, resp);
        chk("rd_ofs", {rdat[29:0], resp}, 32'h2);
        host.rd(6'h0C, rdat, resp);
        chk("rd_fs", {rdat[29:0], resp}, 32'h2);
        // Status shows both fill fields written as ones, answered okay
        host.rd(6'h10, rdat, resp);
        chk("status", {rdat[29:0], resp}, 32'hC);
    endtask : t_bad
    initial begin
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_offset();
        t_fs();
        t_bad();
        complete_run();
    end
endmodule : test_i_channel_trim_registers
